/* testbench/tpc_far.sv */
// Far side model: external pin source and master timer start pulse
`timescale 1ns/100ps
module tpc_far (
    input wire ref_clk_i,
    input wire dut_pin_i,
    input wire dut_oe_n_i,
    output wire pin_level_o,
    output reg master_start_o
);
    reg far_en = 1'b0;
    reg far_lvl = 1'b0;
    initial master_start_o = 1'b0;
    // Wire level: channel drives when enable low, else far source or pull-up
    assign pin_level_o = !dut_oe_n_i ? dut_pin_i : (far_en ? far_lvl : 1'b1);
    // Far source drives a new pin level just after an edge
    task drive(input lvl);
        begin
            @(posedge ref_clk_i);
            far_en <= 1'b1;
            far_lvl <= lvl;
        end
    endtask
    // Master timer start: one-cycle pulse in the shared clock
    task pulse;
        begin
            @(posedge ref_clk_i);
            master_start_o <= 1'b1;
            @(posedge ref_clk_i);
            master_start_o <= 1'b0;
        end
    endtask
endmodule

/* testbench/tpc_top_props.sv */
// Checker of port-level timing for the timer channel
`timescale 1ns/100ps
`include "tpc_defines.vh"
module tpc_top_props #(
    parameter US_CYCLES = 4,
    parameter MS_CYCLES = 20
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire clk_en_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire timer_pin_i,
    input wire master_start_i,
    input wire timer_pin_o,
    input wire timer_pin_oe_n_o,
    input wire irq_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Completed write and its address class
    sequence wr_done_s;
        psel_i && penable_i && pwrite_i && pready_o;
    endsequence
    sequence stop_cmd_s;
        wr_done_s ##0 (paddr_i == `TPC_ADDR_CMD && pwdata_i[`TPC_CMD_STOP]);
    endsequence
    wire bad_addr = paddr_i[1:0] != 2'h0 || paddr_i > `TPC_ADDR_IRQ_CLR;
    pready_answer_a: assert property ($rose(penable_i) && psel_i |=> pready_o)
        else $error("pready missing after one wait state");
    pready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    pready_cause_a: assert property (pready_o |-> psel_i && penable_i && $past(psel_i && penable_i))
        else $error("pready outside a held access");
    slverr_map_a: assert property (pready_o && bad_addr |-> pslverr_o)
        else $error("no error on bad address");
    slverr_ok_a: assert property (pslverr_o |-> pready_o && !bad_addr == 1'b0)
        else $error("error on good address or without pready");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer cycle");
    stop_idle_a: assert property (stop_cmd_s |-> ##3 $stable(timer_pin_o) [*2])
        else $error("pin moves after stop");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(pwrite_i && pready_o
        && (paddr_i == `TPC_ADDR_IRQ_CLR || paddr_i == `TPC_ADDR_IRQ_EN)))
        else $error("irq dropped without clear or mask");
endmodule
bind tpc_top tpc_top_props #(.US_CYCLES(US_CYCLES), .MS_CYCLES(MS_CYCLES)) chk_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .timer_pin_i(timer_pin_i),
    .master_start_i(master_start_i), .timer_pin_o(timer_pin_o),
    .timer_pin_oe_n_o(timer_pin_oe_n_o), .irq_o(irq_o));

/* testbench/tpc_top_test.sv */
// Self-checking bench for the timer channel
`timescale 1ns/100ps
`include "tpc_defines.vh"
module tpc_top_test;
    reg ref_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg clk_en_i = 1'b1;
    reg psel_i = 1'b0;
    reg penable_i = 1'b0;
    reg pwrite_i = 1'b0;
    reg [7:0] paddr_i = 8'h00;
    reg [31:0] pwdata_i = 32'h0;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, timer_pin_i, master_start_i, timer_pin_o, timer_pin_oe_n_o, irq_o;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer i, k, j, p, h;
    reg [31:0] rd;
    reg err;
    reg [73:0] rows [0:12];
    tpc_top #(.MS_CYCLES(20), .US_CYCLES(4)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .timer_pin_i(timer_pin_i),
        .master_start_i(master_start_i), .timer_pin_o(timer_pin_o),
        .timer_pin_oe_n_o(timer_pin_oe_n_o), .irq_o(irq_o));
    tpc_far far_u (.ref_clk_i(ref_clk_i), .dut_pin_i(timer_pin_o), .dut_oe_n_i(timer_pin_oe_n_o),
        .pin_level_o(timer_pin_i), .master_start_o(master_start_i));
    // Clock, 4 ns period
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task chk(input [127:0] nm, input [31:0] x, input [31:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== x) begin
                error_cnt = error_cnt + 1;
                $display("FAIL %0s expected %h seen %h", nm, x, g);
            end
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge ref_clk_i);
            penable_i <= 1'b1;
            do begin
                @(posedge ref_clk_i);
                n = n + 1;
            end while (pready_o !== 1'b1 && n < 50);
            rd = prdata_o;
            err = pslverr_o;
            if (n == 50) chk("pready", 1, 0);
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            @(posedge ref_clk_i);
        end
    endtask
    // High time and period of the pin, in cycles
    task meas;
        integer n;
        begin
            n = 0;
            h = 0;
            while (timer_pin_o !== 1'b0 && n < 400) begin @(posedge ref_clk_i); n = n + 1; end
            while (timer_pin_o !== 1'b1 && n < 400) begin @(posedge ref_clk_i); n = n + 1; end
            while (timer_pin_o === 1'b1 && n < 400) begin @(posedge ref_clk_i); n = n + 1; h = h + 1; end
            p = h;
            while (timer_pin_o === 1'b0 && n < 400) begin @(posedge ref_clk_i); n = n + 1; p = p + 1; end
        end
    endtask
    task close_out;
        begin
            $display("checked %0d mismatches %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Watchdog
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        error_cnt = error_cnt + 1;
        close_out;
    end
    // Main sequence
    initial begin
        rows[0] = {1'b0, `TPC_ADDR_CTRL, 32'h0, 32'h0, 1'b0};
        rows[1] = {1'b0, `TPC_ADDR_REPC, 32'h0, 32'h0, 1'b0};
        rows[2] = {1'b0, `TPC_ADDR_STATUS, 32'h0, 32'h0, 1'b0};
        rows[3] = {1'b1, `TPC_ADDR_REPC, 32'h40, 32'h0, 1'b0};
        rows[4] = {1'b1, `TPC_ADDR_REPC, 32'h41, 32'h0, 1'b0};
        rows[5] = {1'b0, `TPC_ADDR_REPC, 32'h0, 32'h40, 1'b0};
        rows[6] = {1'b1, `TPC_ADDR_PHASE, 32'h7ffc_0000, 32'h0, 1'b0};
        rows[7] = {1'b1, `TPC_ADDR_PHASE, 32'h7ffc_0001, 32'h0, 1'b0};
        rows[8] = {1'b1, `TPC_ADDR_PHASE, 32'h0, 32'h0, 1'b0};
        rows[9] = {1'b0, `TPC_ADDR_PHASE, 32'h0, 32'h7ffc_0000, 1'b0};
        rows[10] = {1'b0, `TPC_ADDR_IRQ_STAT, 32'h0, 32'h8, 1'b0};
        rows[11] = {1'b0, 8'h28, 32'h0, 32'h0, 1'b1};
        rows[12] = {1'b1, 8'h02, 32'h1, 32'h0, 1'b1};
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        for (i = 0; i < 13; i = i + 1) begin
            apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
            chk("pslverr", {31'h0, rows[i][0]}, {31'h0, err});
            if (!rows[i][73]) chk("rdata", rows[i][32:1], rd);
        end
        apb(1'b1, `TPC_ADDR_IRQ_CLR, 32'hf);
        apb(1'b1, `TPC_ADDR_CTRL, 32'h15f);
        apb(1'b1, `TPC_ADDR_CMD, 32'h4);
        apb(1'b0, `TPC_ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        $display("test registers done");
        apb(1'b1, `TPC_ADDR_PHASE, 32'h0003_0002);
        for (k = 0; k < 2; k = k + 1) begin
            apb(1'b1, `TPC_ADDR_CTRL, k ? 32'h2 : 32'h0);
            apb(1'b1, `TPC_ADDR_CMD, 32'h1);
            apb(1'b0, `TPC_ADDR_STATUS, 32'h0);
            chk("running", 32'h1, rd & 32'h3);
            for (j = 0; j < 2; j = j + 1) begin
                meas;
                chk("period", k ? 20 : 100, p);
                chk("high", k ? 12 : 60, h);
            end
            apb(1'b1, `TPC_ADDR_CMD, 32'h2);
            repeat (3) @(posedge ref_clk_i);
            chk("stop level", 32'h0, {31'h0, timer_pin_o});
        end
        apb(1'b1, `TPC_ADDR_CTRL, 32'h16);
        repeat (3) @(posedge ref_clk_i);
        chk("idle inverted", 32'h1, {31'h0, timer_pin_o});
        chk("drain enable", 32'h1, {31'h0, timer_pin_oe_n_o});
        apb(1'b1, `TPC_ADDR_CMD, 32'h1);
        meas;
        chk("inverted high", 8, h);
        apb(1'b1, `TPC_ADDR_CMD, 32'h2);
        $display("test pwm done");
        apb(1'b1, `TPC_ADDR_CTRL, 32'h82);
        apb(1'b1, `TPC_ADDR_CMD, 32'h1);
        repeat (30) @(posedge ref_clk_i);
        apb(1'b0, `TPC_ADDR_STATUS, 32'h0);
        chk("armed", 32'h3, rd & 32'h3);
        far_u.pulse;
        apb(1'b0, `TPC_ADDR_STATUS, 32'h0);
        chk("triggered", 32'h1, rd & 32'h3);
        meas;
        chk("trig period", 20, p);
        apb(1'b1, `TPC_ADDR_CMD, 32'h2);
        $display("test trigger done");
        apb(1'b1, `TPC_ADDR_CTRL, 32'h343);
        apb(1'b1, `TPC_ADDR_REPC, 32'h2);
        apb(1'b1, `TPC_ADDR_CMD, 32'h1);
        far_u.drive(1'b0);
        repeat (10) @(posedge ref_clk_i);
        apb(1'b0, `TPC_ADDR_STATUS, 32'h0);
        chk("remaining", 32'h103, rd & 32'hff03);
        far_u.drive(1'b1);
        repeat (39) @(posedge ref_clk_i);
        far_u.drive(1'b0);
        repeat (10) @(posedge ref_clk_i);
        apb(1'b0, `TPC_ADDR_STATUS, 32'h0);
        chk("cap done", 32'h0, rd & 32'hff03);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        apb(1'b1, `TPC_ADDR_CAPIDX, 32'h0);
        apb(1'b0, `TPC_ADDR_CAPDATA, 32'h0);
        chk("cap0", 32'h0, rd);
        apb(1'b1, `TPC_ADDR_CAPIDX, 32'h1);
        apb(1'b0, `TPC_ADDR_CAPDATA, 32'h0);
        chk("cap1 ticks", 32'h1, {31'h0, rd == 32'h9 || rd == 32'ha});
        apb(1'b0, `TPC_ADDR_IRQ_STAT, 32'h0);
        chk("irq stat", 32'h3, rd & 32'h3);
        apb(1'b1, `TPC_ADDR_IRQ_EN, 32'h2);
        chk("irq on", 32'h1, {31'h0, irq_o});
        apb(1'b1, `TPC_ADDR_IRQ_CLR, 32'h2);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        $display("test capture done");
        apb(1'b1, `TPC_ADDR_CTRL, 32'h2);
        apb(1'b1, `TPC_ADDR_CMD, 32'h1);
        repeat (25) @(posedge ref_clk_i);
        // Clock enable low must hold the running waveform still
        clk_en_i <= 1'b0;
        @(posedge ref_clk_i);
        rd = {31'h0, timer_pin_o};
        j = 0;
        repeat (30) begin
            @(posedge ref_clk_i);
            if (timer_pin_o !== rd[0]) j = 1;
        end
        chk("freeze pin", 32'h0, j);
        clk_en_i <= 1'b1;
        $display("test freeze done");
        rst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk("reset pin", 32'h0, {31'h0, timer_pin_o});
        chk("reset oe", 32'h1, {31'h0, timer_pin_oe_n_o});
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        apb(1'b0, `TPC_ADDR_STATUS, 32'h0);
        chk("reset status", 32'h0, rd);
        $display("test reset done");
        close_out;
    end
endmodule

/* verilog/tpc_defines.vh */
// Register map, field positions, reset values and limits of the timer channel
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH
`define TPC_ADDR_CTRL 8'h00
`define TPC_ADDR_CMD 8'h04
`define TPC_ADDR_PHASE 8'h08
`define TPC_ADDR_REPC 8'h0c
`define TPC_ADDR_STATUS 8'h10
`define TPC_ADDR_CAPIDX 8'h14
`define TPC_ADDR_CAPDATA 8'h18
`define TPC_ADDR_IRQ_STAT 8'h1c
`define TPC_ADDR_IRQ_EN 8'h20
`define TPC_ADDR_IRQ_CLR 8'h24
// Control register fields
`define TPC_CTRL_MODE 0
`define TPC_CTRL_DIV_US 1
`define TPC_CTRL_OPEN_DRAIN 2
`define TPC_CTRL_IDLE_HIGH 3
`define TPC_CTRL_INVERT 4
`define TPC_CTRL_CAP_EDGE_LO 5
`define TPC_CTRL_TRIG_LO 7
`define TPC_CTRL_PIN_EDGE_LO 9
`define TPC_CTRL_RESET 11'h000
// Command bits
`define TPC_CMD_START 0
`define TPC_CMD_STOP 1
`define TPC_CMD_RESET 2
// Trigger sources and edge selections
`define TPC_TRIG_NONE 2'h0
`define TPC_TRIG_MASTER 2'h1
`define TPC_TRIG_PIN 2'h2
`define TPC_EDGE_RISE 2'h1
`define TPC_EDGE_FALL 2'h2
`define TPC_EDGE_TOGGLE 2'h0
// Interrupt bits
`define TPC_IRQ_CAPTURE 0
`define TPC_IRQ_DONE 1
`define TPC_IRQ_LIMIT 2
`define TPC_IRQ_BADPHASE 3
// Limits and timing
`define TPC_COUNT_LIMIT 16'h7ffc
`define TPC_REPC_MAX 7'h40
`define TPC_CLK_MHZ 250
`define TPC_TICK_US 1
`define TPC_TICK_MS 1
`define TPC_US_CYCLES (`TPC_TICK_US * `TPC_CLK_MHZ)
`define TPC_MS_CYCLES (`TPC_TICK_MS * 1000 * `TPC_CLK_MHZ)
`endif

/* verilog/tpc_tick.v */
// Tick divider: one pulse every DIV cycles, restartable
`timescale 1ns/100ps
module tpc_tick #(
    parameter WIDTH = 18
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire clk_en_i,
    input wire clear_i,
    input wire [WIDTH-1:0] div_i,
    output reg tick_o
);
    reg [WIDTH-1:0] cnt;

    // Count up to div-1, pulse, wrap
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= {WIDTH{1'b0}};
            tick_o <= 1'b0;
        end else if (clk_en_i) begin
            if (clear_i) begin
                cnt <= {WIDTH{1'b0}};
                tick_o <= 1'b0;
            end else if (cnt >= div_i - {{(WIDTH-1){1'b0}}, 1'b1}) begin
                cnt <= {WIDTH{1'b0}};
                tick_o <= 1'b1;
            end else begin
                cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
                tick_o <= 1'b0;
            end
        end
    end
endmodule

/* verilog/tpc_top.v */
// Timer channel with PWM output, triggered start and edge capture, APB registers
//
// What this block does
// - PWM repeats its two-phase pattern endlessly until stopped or reset.
// - Phase counts 0..32764 each, sum 1..32764; other writes are refused.
// - With master trigger, the start waits for the master timer start pulse.
// - With no trigger source the waveform begins at the start command.
// - Capture latches the counter on rising, falling or both pin edges.
// - Repeat count 0..64 sets capture number; 0 means 64.
// - Capture trigger may be master or pin edge; pin edge defaults toggle.
// - Trigger defaults to none; none again cancels, counting starts at start.
// - Instance two refuses the pin trigger; only master or none remain.
// - Captured values read by index 0..63, index 64 reads zero; index defaults to 0.
// - Capture stops at once when the counter would pass 32764.
// - Trigger starts the counter; earlier edges are captured as zero.
// - Status shows running and captures still remaining.
// - Inversion flips every driven level, pulses and idle alike.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "tpc_defines.vh"
module tpc_top #(
    parameter INSTANCE = 0,
    parameter CAP_DEPTH = 64,
    parameter MS_CYCLES = `TPC_MS_CYCLES,
    parameter US_CYCLES = `TPC_US_CYCLES
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire clk_en_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire timer_pin_i,
    input wire master_start_i,
    output reg timer_pin_o,
    output reg timer_pin_oe_n_o,
    output reg irq_o
);
    localparam [17:0] MS_DIV = MS_CYCLES;
    localparam [17:0] US_DIV = US_CYCLES;
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ARMED = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    reg [10:0] ctrl;
    reg [14:0] first_phase_count;
    reg [14:0] second_phase_count;
    reg [6:0] repc;
    reg [6:0] cap_index;
    reg [3:0] irq_stat;
    reg [3:0] irq_en;
    reg [1:0] state;
    reg [15:0] cnt;
    reg phase;
    reg [6:0] remaining;
    reg [6:0] wr_ptr;
    reg [14:0] cap_mem [0:CAP_DEPTH-1];
    reg pin_s1;
    reg pin_s2;
    reg pin_s3;
    reg [3:0] next_irq_stat;
    reg [31:0] rd_data;
    reg rd_err;
    integer i;

    wire acc = psel_i & penable_i & pready_o;
    wire wr = acc & pwrite_i & ~pslverr_o;
    wire cmd_wr = wr & (paddr_i == `TPC_ADDR_CMD);
    wire do_start = cmd_wr & pwdata_i[`TPC_CMD_START];
    wire do_stop = cmd_wr & pwdata_i[`TPC_CMD_STOP];
    wire do_reset = cmd_wr & pwdata_i[`TPC_CMD_RESET];
    wire mode_cap = ctrl[`TPC_CTRL_MODE];
    wire [1:0] cap_edge = ctrl[`TPC_CTRL_CAP_EDGE_LO+1:`TPC_CTRL_CAP_EDGE_LO];
    wire [1:0] trig = ctrl[`TPC_CTRL_TRIG_LO+1:`TPC_CTRL_TRIG_LO];
    wire [1:0] pin_edge = ctrl[`TPC_CTRL_PIN_EDGE_LO+1:`TPC_CTRL_PIN_EDGE_LO];
    wire rise = pin_s2 & ~pin_s3;
    wire fall = ~pin_s2 & pin_s3;
    wire tick;

    // Edge selection helper: toggle code means either edge
    function edge_hit;
        input [1:0] sel;
        input r;
        input f;
        begin
            edge_hit = (sel == `TPC_EDGE_RISE) ? r : (sel == `TPC_EDGE_FALL) ? f : (r | f);
        end
    endfunction

    wire cap_hit = mode_cap & (state != ST_IDLE) & edge_hit(cap_edge, rise, fall);
    wire pin_trig = mode_cap & (trig == `TPC_TRIG_PIN) & edge_hit(pin_edge, rise, fall);
    wire trig_evt = (trig == `TPC_TRIG_MASTER) ? master_start_i : pin_trig;
    wire [6:0] repc_eff = (repc == 7'h00) ? `TPC_REPC_MAX : repc;
    wire [15:0] phase_sum = {1'b0, pwdata_i[14:0]} + {1'b0, pwdata_i[30:16]};
    wire phase_ok = (pwdata_i[15] == 1'b0) && (pwdata_i[31] == 1'b0) &&
                    (phase_sum != 16'h0000) && (phase_sum <= `TPC_COUNT_LIMIT);
    wire [15:0] cnt_inc = cnt + 16'h0001;
    // Enable mask as it stands after this edge, so irq follows an enable write at once
    wire [3:0] next_irq_en = (wr && paddr_i == `TPC_ADDR_IRQ_EN) ? pwdata_i[3:0] : irq_en;

    // Tick source, restarted at each start and trigger
    tpc_tick #(
        .WIDTH(18)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .clear_i(do_start | (state == ST_ARMED)),
        .div_i(ctrl[`TPC_CTRL_DIV_US] ? US_DIV : MS_DIV),
        .tick_o(tick)
    );

    // Pin synchroniser plus edge history
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1 <= 1'b1; // Pull-up idle level, no false edge after reset
            pin_s2 <= 1'b1;
            pin_s3 <= 1'b1;
        end else if (clk_en_i) begin
            pin_s1 <= timer_pin_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Configuration registers
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= `TPC_CTRL_RESET;
            first_phase_count <= 15'h0000;
            second_phase_count <= 15'h0000;
            repc <= 7'h00;
            cap_index <= 7'h00;
            irq_en <= 4'h0;
        end else if (clk_en_i) begin
            if (do_reset) begin
                ctrl <= `TPC_CTRL_RESET;
                first_phase_count <= 15'h0000;
                second_phase_count <= 15'h0000;
                repc <= 7'h00;
                cap_index <= 7'h00;
            end else if (wr) begin
                case (paddr_i)
                    `TPC_ADDR_CTRL: begin
                        ctrl <= pwdata_i[10:0];
                        if (INSTANCE == 2 && pwdata_i[`TPC_CTRL_TRIG_LO+1:`TPC_CTRL_TRIG_LO] == `TPC_TRIG_PIN) begin
                            ctrl[`TPC_CTRL_TRIG_LO+1:`TPC_CTRL_TRIG_LO] <= `TPC_TRIG_NONE;
                        end
                    end
                    `TPC_ADDR_PHASE: begin
                        if (phase_ok) begin
                            first_phase_count <= pwdata_i[14:0];
                            second_phase_count <= pwdata_i[30:16];
                        end
                    end
                    `TPC_ADDR_REPC: begin
                        if (pwdata_i[6:0] <= `TPC_REPC_MAX) begin
                            repc <= pwdata_i[6:0];
                        end
                    end
                    `TPC_ADDR_CAPIDX: begin
                        if (pwdata_i[6:0] <= `TPC_REPC_MAX) begin
                            cap_index <= pwdata_i[6:0];
                        end
                    end
                    `TPC_ADDR_IRQ_EN: begin
                        irq_en <= pwdata_i[3:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Channel sequencer: arm, run, count, capture
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            cnt <= 16'h0000;
            phase <= 1'b0;
            remaining <= 7'h00;
            wr_ptr <= 7'h00;
            for (i = 0; i < CAP_DEPTH; i = i + 1) begin
                cap_mem[i] <= 15'h0000;
            end
        end else if (clk_en_i) begin
            if (do_stop | do_reset) begin
                state <= ST_IDLE;
                phase <= 1'b0;
            end else if (do_start) begin
                cnt <= 16'h0000;
                phase <= ~mode_cap & (first_phase_count == 15'h0000);
                remaining <= repc_eff;
                wr_ptr <= 7'h00;
                if (trig == `TPC_TRIG_NONE) begin
                    state <= ST_RUN;
                end else begin
                    state <= ST_ARMED;
                end
            end else begin
                if (state == ST_ARMED && trig_evt) begin
                    state <= ST_RUN;
                end
                // Output pattern repeats without limit
                if (state == ST_RUN && !mode_cap && tick) begin
                    if (!phase) begin
                        if (cnt_inc >= {1'b0, first_phase_count}) begin
                            cnt <= 16'h0000;
                            phase <= (second_phase_count != 15'h0000);
                        end else begin
                            cnt <= cnt_inc;
                        end
                    end else begin
                        if (cnt_inc >= {1'b0, second_phase_count}) begin
                            cnt <= 16'h0000;
                            phase <= (first_phase_count == 15'h0000);
                        end else begin
                            cnt <= cnt_inc;
                        end
                    end
                end
                // Capture counter runs only after the trigger
                if (state == ST_RUN && mode_cap && tick) begin
                    if (cnt == `TPC_COUNT_LIMIT) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt_inc;
                    end
                end
                // Latch the counter, zero while still armed
                if (cap_hit && remaining != 7'h00) begin
                    cap_mem[wr_ptr[5:0]] <= (state == ST_RUN) ? cnt[14:0] : 15'h0000;
                    wr_ptr <= wr_ptr + 7'h01;
                    remaining <= remaining - 7'h01;
                    if (remaining == 7'h01) begin
                        state <= ST_IDLE;
                    end
                end
            end
        end
    end

    // Sticky events, set wins over clear
    always @* begin
        next_irq_stat = irq_stat;
        if (wr && paddr_i == `TPC_ADDR_IRQ_CLR) begin
            next_irq_stat = irq_stat & ~pwdata_i[3:0];
        end
        if (cap_hit && remaining != 7'h00 && !(do_stop | do_reset | do_start)) begin
            next_irq_stat[`TPC_IRQ_CAPTURE] = 1'b1;
            if (remaining == 7'h01) begin
                next_irq_stat[`TPC_IRQ_DONE] = 1'b1;
            end
        end
        if (state == ST_RUN && mode_cap && tick && cnt == `TPC_COUNT_LIMIT && !(do_stop | do_reset | do_start)) begin
            next_irq_stat[`TPC_IRQ_LIMIT] = 1'b1;
        end
        if (wr && paddr_i == `TPC_ADDR_PHASE && !phase_ok) begin
            next_irq_stat[`TPC_IRQ_BADPHASE] = 1'b1;
        end
    end

    // Read multiplexer and unmapped-address decode
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr_i)
            `TPC_ADDR_CTRL: rd_data = {21'h000000, ctrl};
            `TPC_ADDR_CMD: rd_data = 32'h0000_0000;
            `TPC_ADDR_PHASE: rd_data = {1'b0, second_phase_count, 1'b0, first_phase_count};
            `TPC_ADDR_REPC: rd_data = {25'h0000000, repc};
            `TPC_ADDR_STATUS: rd_data = {16'h0000, 1'b0, remaining, 6'h00, (state == ST_ARMED),
                                         (state != ST_IDLE)};
            `TPC_ADDR_CAPIDX: rd_data = {25'h0000000, cap_index};
            `TPC_ADDR_CAPDATA: rd_data = (cap_index < CAP_DEPTH) ?
                                         {17'h00000, cap_mem[cap_index[5:0]]} : 32'h0000_0000;
            `TPC_ADDR_IRQ_STAT: rd_data = {28'h0000000, irq_stat};
            `TPC_ADDR_IRQ_EN: rd_data = {28'h0000000, irq_en};
            `TPC_ADDR_IRQ_CLR: rd_data = 32'h0000_0000;
            default: rd_err = 1'b1;
        endcase
        if (paddr_i[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end
    end

    // APB answer with one wait state, interrupt line
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            irq_stat <= 4'h0;
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            pready_o <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & rd_err;
            if (psel_i & penable_i & ~pready_o & ~pwrite_i) begin
                prdata_o <= rd_data;
            end else if (acc) begin
                prdata_o <= 32'h0000_0000;
            end
            irq_stat <= next_irq_stat;
            irq_o <= |(next_irq_stat & next_irq_en);
        end
    end

    // Pin driver: idle level, active phase, inversion, drive kind
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            timer_pin_o <= 1'b0;
            timer_pin_oe_n_o <= 1'b1;
        end else if (clk_en_i) begin
            timer_pin_o <= ctrl[`TPC_CTRL_IDLE_HIGH] ^ (~mode_cap & (state == ST_RUN) & phase) ^
                           ctrl[`TPC_CTRL_INVERT];
            if (mode_cap) begin
                timer_pin_oe_n_o <= 1'b1;
            end else if (ctrl[`TPC_CTRL_OPEN_DRAIN]) begin
                timer_pin_oe_n_o <= ctrl[`TPC_CTRL_IDLE_HIGH] ^ (~mode_cap & (state == ST_RUN) & phase) ^
                                    ctrl[`TPC_CTRL_INVERT];
            end else begin
                timer_pin_oe_n_o <= 1'b0;
            end
        end
    end
endmodule
